// >>> hw/bit_accum_pkg.sv
// package of constants and types for the single-bit accumulator datapath
// assumes one core clock domain and a sequencer that issues one operation at a time
//
// Behaviour
// - one accumulator bit, source and destination
// - force high selector sets accumulator
// - force low selector clears accumulator
// - force complement selector inverts accumulator
// - force status selector copies chosen status flag
// - operands are one-bit states of any resource
// - load copies operand state into accumulator
// - and combines accumulator with operand
// - or combines accumulator with operand
// - xor combines accumulator with operand
// - output copy writes accumulator, accumulator unchanged
// - inverted variants invert operand before function
// - edge detect keeps high only on rise
// - set and clear act only when accumulator high
// - four status flags positive negative zero error
package bit_accum_pkg;

  // ****************************************
  // operation codes
  // ****************************************
  typedef enum logic [3:0] {
    op_nop,
    accumulator_force_op,
    load_high_op,
    load_inverted_op,
    and_high_op,
    and_inverted_op,
    or_high_op,
    or_inverted_op,
    xor_op,
    output_copy_op,
    edge_detect_op,
    conditional_set_op,
    conditional_clear_op,
    conditional_invert_op
  } bit_op_t;

  // ****************************************
  // force selectors
  // ****************************************
  typedef enum logic [2:0] {
    sel_high,
    sel_low,
    sel_complement,
    sel_positive,
    sel_negative,
    sel_zero,
    sel_error
  } force_sel_t;

  localparam logic ACCU_RESET = 1'h0;
  localparam int   STATUS_W   = 4;
  localparam int   POS_BIT    = 0;
  localparam int   NEG_BIT    = 1;
  localparam int   ZERO_BIT   = 2;
  localparam int   ERR_BIT    = 3;

endpackage

// >>> hw/bit_logic_unit.sv
// combinational one-bit function unit for the accumulator datapath
// assumes operand already inverted or not by the caller
`timescale 1ns/100ps
module bit_logic_unit (
  // operation and inputs
  input  wire bit_accum_pkg::bit_op_t op,
  input  wire logic                   accu,
  input  wire logic                   operand,
  input  wire logic                   edge_mem,
  // result
  output logic                        accu_next,
  output logic                        keep_accu
);

  always_comb begin
    accu_next = accu;
    keep_accu = 1'h0;
    case (op)
      bit_accum_pkg::load_high_op,
      bit_accum_pkg::load_inverted_op: accu_next = operand;
      bit_accum_pkg::and_high_op,
      bit_accum_pkg::and_inverted_op:  accu_next = accu & operand;
      bit_accum_pkg::or_high_op,
      bit_accum_pkg::or_inverted_op:   accu_next = accu | operand;
      bit_accum_pkg::xor_op:           accu_next = accu ^ operand;
      bit_accum_pkg::edge_detect_op:   accu_next = accu & ~edge_mem;
      default:                         keep_accu = 1'h1;
    endcase
  end

endmodule

// >>> hw/bit_accumulator.sv
// single-bit accumulator datapath of the controller core
// assumes the sequencer presents op with operand state and edge flag state in the same cycle
`timescale 1ns/100ps
module bit_accumulator (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  // operation from sequencer
  input  wire logic                       op_valid,
  input  wire bit_accum_pkg::bit_op_t     op,
  input  wire bit_accum_pkg::force_sel_t  force_sel,
  input  wire logic                       operand_state,
  input  wire logic                       edge_flag_state,
  input  wire logic [3:0]                 status_flags,
  // results
  output logic                            accu,
  output logic                            wr_en,
  output logic                            wr_value,
  output logic                            edge_flag_wr_en,
  output logic                            edge_flag_value
);

  typedef struct packed {
    logic accu;
    logic wr_en;
    logic wr_value;
    logic edge_en;
    logic edge_val;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic   inv_op;
  logic   eff_operand;
  logic   alu_next;
  logic   alu_keep;

  // ****************************************
  // operand conditioning
  // ****************************************
  assign inv_op = (op == bit_accum_pkg::load_inverted_op) ||
                  (op == bit_accum_pkg::and_inverted_op) ||
                  (op == bit_accum_pkg::or_inverted_op);
  assign eff_operand = operand_state ^ inv_op;

  bit_logic_unit u_unit (
    .op        (op),
    .accu      (s_q.accu),
    .operand   (eff_operand),
    .edge_mem  (edge_flag_state),
    .accu_next (alu_next),
    .keep_accu (alu_keep)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d          = s_q;
    s_d.wr_en    = 1'h0;
    s_d.edge_en  = 1'h0;
    if (op_valid) begin
      if (!alu_keep) begin
        s_d.accu = alu_next;
      end
      case (op)
        bit_accum_pkg::accumulator_force_op: begin
          case (force_sel)
            bit_accum_pkg::sel_high:       s_d.accu = 1'h1;
            bit_accum_pkg::sel_low:        s_d.accu = 1'h0;
            bit_accum_pkg::sel_complement: s_d.accu = ~s_q.accu;
            bit_accum_pkg::sel_positive:
              s_d.accu = status_flags[bit_accum_pkg::POS_BIT];
            bit_accum_pkg::sel_negative:
              s_d.accu = status_flags[bit_accum_pkg::NEG_BIT];
            bit_accum_pkg::sel_zero:
              s_d.accu = status_flags[bit_accum_pkg::ZERO_BIT];
            bit_accum_pkg::sel_error:
              s_d.accu = status_flags[bit_accum_pkg::ERR_BIT];
            default:                       s_d.accu = s_q.accu;
          endcase
        end
        bit_accum_pkg::output_copy_op: begin
          s_d.wr_en    = 1'h1;
          s_d.wr_value = s_q.accu;
        end
        bit_accum_pkg::conditional_set_op: begin
          s_d.wr_en    = s_q.accu;
          s_d.wr_value = 1'h1;
        end
        bit_accum_pkg::conditional_clear_op: begin
          s_d.wr_en    = s_q.accu;
          s_d.wr_value = 1'h0;
        end
        bit_accum_pkg::conditional_invert_op: begin
          s_d.wr_en    = s_q.accu;
          s_d.wr_value = ~operand_state;
        end
        bit_accum_pkg::edge_detect_op: begin
          s_d.edge_en  = 1'h1;
          s_d.edge_val = s_q.accu;
        end
        default: begin
          s_d.wr_en    = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_q <= '{accu: bit_accum_pkg::ACCU_RESET, default: 1'h0};
    end else begin
      s_q <= s_d;
    end
  end

  assign accu            = s_q.accu;
  assign wr_en           = s_q.wr_en;
  assign wr_value        = s_q.wr_value;
  assign edge_flag_wr_en = s_q.edge_en;
  assign edge_flag_value = s_q.edge_val;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_FORCE_HIGH: assert property (op_valid && op == bit_accum_pkg::accumulator_force_op
    && force_sel == bit_accum_pkg::sel_high |=> accu) else $error("force high failed");
  AST_FORCE_LOW: assert property (op_valid && op == bit_accum_pkg::accumulator_force_op
    && force_sel == bit_accum_pkg::sel_low |=> !accu) else $error("force low failed");
  AST_FORCE_COMP: assert property (op_valid && op == bit_accum_pkg::accumulator_force_op
    && force_sel == bit_accum_pkg::sel_complement |=> accu != $past(accu))
    else $error("complement failed");
  AST_FORCE_ZERO: assert property (op_valid && op == bit_accum_pkg::accumulator_force_op
    && force_sel == bit_accum_pkg::sel_zero |=> accu == $past(status_flags[2]))
    else $error("status copy failed");
  AST_LOAD_INV: assert property (op_valid && op == bit_accum_pkg::load_inverted_op
    |=> accu == !$past(operand_state)) else $error("inverted load failed");
  AST_AND: assert property (op_valid && op == bit_accum_pkg::and_high_op
    |=> accu == ($past(accu) & $past(operand_state))) else $error("and failed");
  AST_OR: assert property (op_valid && op == bit_accum_pkg::or_high_op
    |=> accu == ($past(accu) | $past(operand_state))) else $error("or failed");
  AST_XOR: assert property (op_valid && op == bit_accum_pkg::xor_op
    |=> accu == ($past(accu) ^ $past(operand_state))) else $error("xor failed");
  AST_COPY: assert property (op_valid && op == bit_accum_pkg::output_copy_op
    |=> wr_en && wr_value == $past(accu) && $stable(accu)) else $error("copy failed");
  AST_EDGE: assert property (op_valid && op == bit_accum_pkg::edge_detect_op
    |=> accu == ($past(accu) && !$past(edge_flag_state)) && edge_flag_wr_en
    && edge_flag_value == $past(accu)) else $error("edge detect failed");
  AST_SET_GATED: assert property (op_valid && op == bit_accum_pkg::conditional_set_op
    && !accu |=> !wr_en) else $error("set fired with low accumulator");

  COV_EDGE_RISE: cover property (op_valid && op == bit_accum_pkg::edge_detect_op
    && accu && !edge_flag_state);
  COV_SET: cover property (op_valid && op == bit_accum_pkg::conditional_set_op && accu);
  COV_CHAIN: cover property (op_valid && op == bit_accum_pkg::load_high_op
    ##1 op_valid && op == bit_accum_pkg::and_high_op);

endmodule

// >>> testbench/resource_image.sv
// resource image standing in for the sequencer's operand side
// assumes writes and edge flag stores come one cycle after the taking edge
`timescale 1ns/100ps
module resource_image #(
  parameter logic [7:0] INIT = 8'h5a
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // operand select and read
  input  wire logic [2:0] addr,
  output logic            operand_state,
  output logic            edge_flag_state,
  // writes from the datapath
  input  wire logic       wr_en,
  input  wire logic       wr_value,
  input  wire logic       edge_flag_wr_en,
  input  wire logic       edge_flag_value
);
  // ****************************************
  // image and edge flag
  // ****************************************
  logic [7:0] mem_q;
  logic [2:0] addr_q;
  logic       flag_q;
  assign operand_state   = mem_q[addr];
  assign edge_flag_state = flag_q;
  // a write lands on the operand selected when its op was taken
  always_ff @(posedge core_clk) begin
    addr_q <= addr;
    if (!rst_n) begin
      mem_q  <= INIT;
      flag_q <= 1'h0;
    end else begin
      if (wr_en) mem_q[addr_q] <= wr_value;
      if (edge_flag_wr_en) flag_q <= edge_flag_value;
    end
  end
endmodule

// >>> testbench/testbench.sv
// self-checking bench of the single-bit accumulator datapath
// assumes the resource image supplies operands and takes writes
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("FAIL %s expected %h seen %h", nm, e, g); end end
module testbench;
  logic                      core_clk, rst_n, op_valid;
  bit_accum_pkg::bit_op_t    op;
  bit_accum_pkg::force_sel_t force_sel;
  logic [2:0]                addr;
  logic                      operand_state, edge_flag_state, accu;
  logic                      wr_en, wr_value, edge_flag_wr_en, edge_flag_value;
  int                        failures, checked;
  logic [15:0]               r;
  // row nibbles: op, selector, address, {0, accu, write, write value}
  logic [15:0] rows [34] = '{
    16'h1004, 16'h1100, 16'h1204, 16'h1400, 16'h1304, 16'h1500, 16'h1604,
    16'h2014, 16'h2000, 16'h3004, 16'h4034, 16'h5030, 16'h6044, 16'h4020,
    16'h7054, 16'h8060, 16'h8070, 16'h8064, 16'h9077, 16'hc066, 16'hb057,
    16'hd046, 16'h1100, 16'hb000, 16'ha000, 16'h1004, 16'ha004, 16'h1004,
    16'h2014, 16'ha000, 16'h2074, 16'h2040, 16'h2060, 16'h2054};

  bit_accumulator bit_accumulator_i (
    .core_clk(core_clk), .rst_n(rst_n), .op_valid(op_valid), .op(op),
    .force_sel(force_sel), .operand_state(operand_state),
    .edge_flag_state(edge_flag_state), .status_flags(4'h9), .accu(accu),
    .wr_en(wr_en), .wr_value(wr_value), .edge_flag_wr_en(edge_flag_wr_en),
    .edge_flag_value(edge_flag_value));
  resource_image resource_image_i (
    .core_clk(core_clk), .rst_n(rst_n), .addr(addr),
    .operand_state(operand_state), .edge_flag_state(edge_flag_state),
    .wr_en(wr_en), .wr_value(wr_value), .edge_flag_wr_en(edge_flag_wr_en),
    .edge_flag_value(edge_flag_value));

  // ****************************************
  // clock, verdict and watchdog
  // ****************************************
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic final_report;
    if (failures == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge core_clk);
    failures++;
    final_report();
  end

  // ****************************************
  // table run, then hand tests
  // ****************************************
  initial begin
    failures = 0;
    checked = 0;
    rst_n = 1'h0;
    op_valid = 1'h0;
    op = bit_accum_pkg::op_nop;
    force_sel = bit_accum_pkg::sel_high;
    addr = 3'h0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'h1;
    for (int k = 0; k <= 34; k++) begin
      @(posedge core_clk);
      if (k < 34) begin
        op_valid  <= 1'h1;
        op        <= bit_accum_pkg::bit_op_t'(rows[k][15:12]);
        force_sel <= bit_accum_pkg::force_sel_t'(rows[k][10:8]);
        addr      <= rows[k][6:4];
      end else op_valid <= 1'h0;
      if (k > 0) begin
        #1;
        r = rows[k-1];
        `CHK("accu", r[2], accu)
        `CHK("wr_en", r[1], wr_en)
        if (r[1]) `CHK("wr_value", r[0], wr_value)
      end
    end
    // idle strobe must leave the accumulator alone
    op        <= bit_accum_pkg::accumulator_force_op;
    force_sel <= bit_accum_pkg::sel_low;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("accu idle", 1'h1, accu)
    @(posedge core_clk);
    rst_n <= 1'h0;
    @(posedge core_clk);
    #1;
    `CHK("accu reset", 1'h0, accu)
    `CHK("wr_en reset", 1'h0, wr_en)
    rst_n <= 1'h1;
    final_report();
  end
endmodule
